/* hdl/lasf_pkg.sv */
// shared constants, codes and carriers of the activation status block
package lasf_pkg;

  // wishbone register byte offsets
  localparam int         ADR_W    = 4;
  localparam logic [3:0] REG_CMD  = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_OVH  = 4'h8;

  // status register field positions
  localparam int STAT_PWR_BIT = 4;
  localparam int STAT_ST_LSB  = 16;

  // clock and time figures
  localparam int CLK_NS        = 40;
  localparam int FRAMES_PER_MS = 8;
  localparam int SLIP_NS       = 1500000;
  localparam int SLIP_CYC      = (SLIP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUPERVISOR_MS = 15000;
  localparam int TONE_TX_MS    = 3;
  localparam int EC_TRAIN_MS   = 1000;
  localparam int SYNC_WAIT_MS  = 6000;
  localparam int RX_HOLD_MS    = 40;
  localparam int READY_MS      = 24;
  localparam int ERR_HOLD_MS   = 40;
  localparam int WARN_MS       = 40;

  // wake-up tone period counts
  localparam int TONE_POWERUP = 8;
  localparam int TONE_DETECT  = 12;

  // commands written by the host controller
  typedef enum logic [3:0] {
    CMD_IDLE       = 4'h0,
    CMD_TEARDOWN   = 4'h1,
    CMD_RX_CLEAR   = 4'h2,
    CMD_WAKEUP     = 4'h3,
    CMD_LOOP2      = 4'h4,
    CMD_LINE_ONLY  = 4'h5,
    CMD_EXT_REQ    = 4'h6,
    CMD_LOCAL_LOOP = 4'h7,
    CMD_ST_RESET   = 4'h8,
    CMD_TEST       = 4'h9
  } lasf_cmd_t;

  // status codes returned to the host
  typedef enum logic [3:0] {
    CODE_IDLE          = 4'h0,
    CODE_READY         = 4'h1,
    CODE_WAKEUP        = 4'h2,
    CODE_SHUTDOWN_ACK  = 4'h3,
    CODE_FAR_LOSS      = 4'h4,
    CODE_STARTUP_FAIL  = 4'h5,
    CODE_SIGNAL_LOSS   = 4'h6,
    CODE_FRAMING_LOSS  = 4'h7,
    CODE_FRAME_SLIP    = 4'h8,
    CODE_LINE_SYNC     = 4'h9
  } lasf_code_t;

  // line signal classes sent downstream
  typedef enum logic [2:0] {
    SIG_NONE       = 3'h0,
    SIG_LOCAL_TONE = 3'h1,
    SIG_EC_TRAIN   = 3'h2,
    SIG_SYNC_TX    = 3'h3,
    SIG_DATA       = 3'h4
  } lasf_sig_t;

  // one-hot activation states
  typedef enum logic [15:0] {
    ST_RESET       = 16'h0001,
    ST_TEST        = 16'h0002,
    ST_DEACT       = 16'h0004,
    ST_ALERT       = 16'h0008,
    ST_ALERT_ERR   = 16'h0010,
    ST_AWAKE       = 16'h0020,
    ST_AWAKE_ERR   = 16'h0040,
    ST_EC_TRAIN    = 16'h0080,
    ST_EC_CONV     = 16'h0100,
    ST_LINE_ON     = 16'h0200,
    ST_PEND_TRANSP = 16'h0400,
    ST_TRANSP      = 16'h0800,
    ST_PEND_DEACT  = 16'h1000,
    ST_TEAR_DOWN   = 16'h2000,
    ST_SIG_LOSS    = 16'h4000,
    ST_RX_RESET    = 16'h8000
  } lasf_state_t;

  // receiver and link inputs, all from outside the clock domain
  typedef struct packed {
    logic bit_clock_line;
    logic frame_sync_line;
    logic tone_env;
    logic tone_wave;
    logic residual_level_seen;
    logic residual_quiet;
    logic long_signal_loss;
    logic framing_lost;
    logic link_up_rx;
    logic subscriber_side_active_bit;
    logic sai_valid;
    logic buffer_slip;
  } lasf_line_t;

  // overhead bits and signal class sent downstream
  typedef struct packed {
    logic      link_up_flag;
    logic      shutdown_warn_bit;
    logic      u_only_flag;
    lasf_sig_t tx_sig;
  } lasf_ovh_t;

endpackage

/* hdl/lasf_sync.sv */
`timescale 1ns/1ns
// two-flop synchroniser for a bundle of asynchronous inputs
module lasf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // the first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta_ff <= 1'b0;
        sync_ff <= 1'b0;
      end else begin
        meta_ff <= d_i[i];
        sync_ff <= meta_ff;
      end
    end
    assign q_o[i] = sync_ff;
  end

endmodule

/* hdl/lasf_top.sv */
`timescale 1ns/1ns
// exchange-side activation and status state machine of one line port

// Overview of operation
// - ready code needs far link-up, delay, no loop
// - wake-up code on tone start or subscriber active
// - shutdown ack on teardown, reset, test
// - far loss code while transparent, not looped, and link-up bit is zero
// - startup fail code when supervisor expires
// - signal loss and framing loss codes
// - line sync code once both directions synced
// - overhead bits sent with plain polarity, except the shutdown warn bit, which is active low
// - u-only flag follows host command or subscriber
// - alerting sends local tone for 3 ms
// - supervisor expiry in alerting holds alert error
// - remote tone enters awake, restarts supervisor
// - awake error only from receive reset
// - deactivated line silent, requests start activation
// - after remote tone, requests wait for idle
// - tone periods: 8 powers up, 12 leaves
// - EC converged sends sync signal, waits
// - EC training sends training signal, waits
// - ready code 24 ms after link-up sent
module lasf_top
  import lasf_pkg::*;
#(
  parameter int SUP_MS      = SUPERVISOR_MS,
  parameter int EC_MS       = EC_TRAIN_MS,
  parameter int SYNC_MS     = SYNC_WAIT_MS,
  parameter int MS_FRAMES   = FRAMES_PER_MS,
  parameter int SLIP_CYCLES = SLIP_CYC
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // receiver, tone detector and system bus timing
  input  wire lasf_line_t       line_i,
  // status and downstream outputs
  output lasf_code_t            status_code_o,
  output lasf_ovh_t             ovh_o,
  output logic                  line_out_pos_o,
  output logic                  line_out_neg_o,
  output logic                  powered_up_o
);

  logic [$bits(lasf_line_t)-1:0] ln_v;
  lasf_line_t  ln;
  lasf_line_t  ln_d_ff;
  lasf_cmd_t   cmd_ff;
  lasf_state_t state_ff;
  lasf_state_t nxt_state;
  lasf_code_t  code_ff;
  lasf_code_t  nxt_code;
  lasf_ovh_t   ovh_ff;
  lasf_ovh_t   nxt_ovh;
  logic [3:0]  frm_cnt_ff;
  logic [9:0]  bclk_cnt_ff;
  logic [9:0]  bclk_last_ff;
  logic [1:0]  frm_seen_ff;
  logic [15:0] slip_cnt_ff;
  logic [15:0] ms_cnt_ff;
  logic [15:0] sup_cnt_ff;
  logic        sup_run_ff;
  logic [3:0]  tone_cnt_ff;
  logic        tone_seen_ff;
  logic        exch_ff;
  logic        analog_ff;
  logic        line_only_ff;
  logic        sai_ok_ff;
  logic        pos_ff;
  logic        neg_ff;
  logic        pwr_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic        frame_rise;
  logic        bclk_rise;
  logic        tone_rise;
  logic        slip_rise;
  logic        ms_tick;
  logic        phase_jump;
  logic        tone_ok;
  logic        sup_done;
  logic        host_req;
  logic        loop_on;
  logic        wb_req;

  // pins cross into the clock domain before anything reads them
  lasf_sync #(
    .W ($bits(lasf_line_t))
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (line_i),
    .q_o     (ln_v)
  );
  assign ln = lasf_line_t'(ln_v);

  // edge finding on the synchronised copies
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ln_d_ff <= '0;
    end else begin
      ln_d_ff <= ln;
    end
  end
  assign frame_rise = ln.frame_sync_line & ~ln_d_ff.frame_sync_line;
  assign bclk_rise  = ln.bit_clock_line & ~ln_d_ff.bit_clock_line;
  assign tone_rise  = ln.tone_wave & ~ln_d_ff.tone_wave;
  assign slip_rise  = ln.buffer_slip & ~ln_d_ff.buffer_slip;

  // millisecond tick from frame sync edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frm_cnt_ff <= 4'h0;
    end else if (frame_rise) begin
      frm_cnt_ff <= ms_tick ? 4'h0 : frm_cnt_ff + 4'h1;
    end
  end
  assign ms_tick = frame_rise && (frm_cnt_ff == 4'(MS_FRAMES - 1));

  // bit clocks per frame; a changed count is a phase jump
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bclk_cnt_ff  <= 10'h000;
      bclk_last_ff <= 10'h000;
      frm_seen_ff  <= 2'h0;
    end else if (frame_rise) begin
      bclk_cnt_ff  <= 10'h000;
      bclk_last_ff <= bclk_cnt_ff;
      if (!frm_seen_ff[1]) begin
        frm_seen_ff <= frm_seen_ff + 2'h1;
      end
    end else if (bclk_rise) begin
      bclk_cnt_ff <= bclk_cnt_ff + 10'h001;
    end
  end
  // the first two frames only fill the counters
  assign phase_jump = frame_rise && frm_seen_ff[1]
                      && (bclk_cnt_ff != bclk_last_ff);

  // frame slip hold; a new slip restarts the full period
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slip_cnt_ff <= 16'h0000;
    end else if (phase_jump || slip_rise) begin
      slip_cnt_ff <= 16'(SLIP_CYCLES);
    end else if (slip_cnt_ff != 16'h0000) begin
      slip_cnt_ff <= slip_cnt_ff - 16'h0001;
    end
  end

  // consecutive tone periods while the envelope is present
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tone_cnt_ff <= 4'h0;
    end else if (!ln.tone_env) begin
      tone_cnt_ff <= 4'h0;
    end else if (tone_rise && !tone_ok) begin
      tone_cnt_ff <= tone_cnt_ff + 4'h1;
    end
  end
  assign tone_ok = tone_cnt_ff >= 4'(TONE_DETECT);

  // remembered remote tone blocks requests; the set wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tone_seen_ff <= 1'b0;
    end else if (state_ff == ST_DEACT && tone_ok) begin
      tone_seen_ff <= 1'b1;
    end else if (cmd_ff == CMD_IDLE || state_ff != ST_DEACT) begin
      tone_seen_ff <= 1'b0;
    end
  end

  assign host_req = cmd_ff inside {CMD_WAKEUP, CMD_LOOP2,
                                   CMD_LINE_ONLY, CMD_LOCAL_LOOP};
  assign loop_on  = analog_ff || (cmd_ff == CMD_LOOP2);
  assign sup_done = sup_run_ff && (sup_cnt_ff >= 16'(SUP_MS));

  // activation mode, latched when leaving the deactivated state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exch_ff      <= 1'b0;
      analog_ff    <= 1'b0;
      line_only_ff <= 1'b0;
    end else if (state_ff == ST_DEACT) begin
      exch_ff      <= nxt_state == ST_ALERT;
      analog_ff    <= (nxt_state == ST_ALERT)
                      && (cmd_ff == CMD_LOCAL_LOOP);
      line_only_ff <= (nxt_state == ST_ALERT)
                      && (cmd_ff == CMD_LINE_ONLY);
    end
  end

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET: begin
        if (cmd_ff == CMD_TEARDOWN) nxt_state = ST_DEACT;
      end
      ST_TEST: begin
        if (cmd_ff inside {CMD_TEARDOWN, CMD_RX_CLEAR}) nxt_state = ST_DEACT;
      end
      ST_DEACT: begin
        if (tone_ok && cmd_ff == CMD_IDLE) nxt_state = ST_AWAKE;
        else if (host_req && !tone_seen_ff) nxt_state = ST_ALERT;
      end
      ST_ALERT: begin
        if (sup_done) nxt_state = ST_ALERT_ERR;
        else if (tone_ok) nxt_state = ST_AWAKE;
        // the looped local tone counts as heard once sent
        else if (analog_ff && ms_cnt_ff >= 16'(TONE_TX_MS))
          nxt_state = ST_AWAKE;
      end
      ST_ALERT_ERR, ST_SIG_LOSS: begin
        if (cmd_ff == CMD_RX_CLEAR) nxt_state = ST_RX_RESET;
      end
      ST_AWAKE, ST_AWAKE_ERR: begin
        // the error variant holds before it may move on
        if ((!ln.tone_env || analog_ff) && (state_ff == ST_AWAKE
            || ms_cnt_ff >= 16'(ERR_HOLD_MS)))
          nxt_state = ST_EC_TRAIN;
      end
      ST_EC_TRAIN: begin
        if (ln.residual_quiet || ms_cnt_ff >= 16'(EC_MS))
          nxt_state = ST_EC_CONV;
      end
      ST_EC_CONV: begin
        if (ln.residual_level_seen || analog_ff
            || ms_cnt_ff >= 16'(SYNC_MS))
          nxt_state = ST_LINE_ON;
      end
      ST_LINE_ON: begin
        if (ln.link_up_rx && !loop_on) nxt_state = ST_PEND_TRANSP;
      end
      ST_PEND_TRANSP: begin
        if (ms_cnt_ff >= 16'(READY_MS)) nxt_state = ST_TRANSP;
      end
      // a lost far-side link-up only changes the code, never the state
      ST_TRANSP: nxt_state = state_ff;
      ST_PEND_DEACT: begin
        if (ms_cnt_ff >= 16'(WARN_MS)) nxt_state = ST_TEAR_DOWN;
      end
      ST_TEAR_DOWN: begin
        if (ln.long_signal_loss) nxt_state = ST_DEACT;
      end
      ST_RX_RESET: begin
        if (tone_ok) nxt_state = ST_AWAKE_ERR;
        else if (ms_cnt_ff >= 16'(RX_HOLD_MS) && cmd_ff != CMD_RX_CLEAR)
          nxt_state = ST_DEACT;
      end
      default: nxt_state = ST_DEACT;
    endcase
    // failures of a synchronised line, then teardown
    if (state_ff inside {ST_LINE_ON, ST_PEND_TRANSP, ST_TRANSP}) begin
      if (ln.long_signal_loss) nxt_state = ST_SIG_LOSS;
      else if (ln.framing_lost) nxt_state = ST_TEAR_DOWN;
    end
    if (cmd_ff == CMD_TEARDOWN && state_ff inside {ST_ALERT, ST_AWAKE,
        ST_EC_TRAIN, ST_EC_CONV, ST_LINE_ON, ST_PEND_TRANSP, ST_TRANSP})
      nxt_state = ST_PEND_DEACT;
    // unconditional commands win everywhere
    if (cmd_ff == CMD_ST_RESET) nxt_state = ST_RESET;
    else if (cmd_ff == CMD_TEST) nxt_state = ST_TEST;
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_DEACT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // per-state timer restarts on every state change
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ms_cnt_ff <= 16'h0000;
    end else if (nxt_state != state_ff) begin
      ms_cnt_ff <= 16'h0000;
    end else if (ms_tick && ms_cnt_ff != 16'hFFFF) begin
      ms_cnt_ff <= ms_cnt_ff + 16'h0001;
    end
  end

  // start-up supervisor spans several states
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sup_cnt_ff <= 16'h0000;
      sup_run_ff <= 1'b0;
    end else if ((state_ff == ST_DEACT && nxt_state != ST_DEACT)
                 || (state_ff == ST_ALERT && nxt_state == ST_AWAKE
                     && exch_ff)) begin
      sup_cnt_ff <= 16'h0000;
      sup_run_ff <= 1'b1;
    end else if (nxt_state inside {ST_LINE_ON, ST_DEACT, ST_RX_RESET}) begin
      sup_run_ff <= 1'b0;
    end else if (ms_tick && sup_run_ff && !sup_done) begin
      sup_cnt_ff <= sup_cnt_ff + 16'h0001;
    end
  end

  // status code towards the host
  always_comb begin
    nxt_code = CODE_IDLE;
    unique case (state_ff)
      ST_RESET, ST_TEST, ST_PEND_DEACT, ST_TEAR_DOWN:
        nxt_code = CODE_SHUTDOWN_ACK;
      ST_ALERT_ERR: nxt_code = CODE_STARTUP_FAIL;
      ST_AWAKE, ST_AWAKE_ERR, ST_EC_TRAIN, ST_EC_CONV:
        nxt_code = sup_done ? CODE_STARTUP_FAIL : CODE_WAKEUP;
      ST_LINE_ON, ST_PEND_TRANSP:
        nxt_code = (line_only_ff && ln.subscriber_side_active_bit)
                   ? CODE_WAKEUP : CODE_LINE_SYNC;
      ST_TRANSP: begin
        if (loop_on) nxt_code = CODE_LINE_SYNC;
        else if (ln.link_up_rx) nxt_code = CODE_READY;
        else nxt_code = CODE_FAR_LOSS;
      end
      ST_SIG_LOSS: nxt_code = CODE_SIGNAL_LOSS;
      default: nxt_code = CODE_IDLE;
    endcase
    // framing loss is reported while the teardown runs
    if (state_ff == ST_TEAR_DOWN && ln.framing_lost)
      nxt_code = CODE_FRAMING_LOSS;
    if (slip_cnt_ff != 16'h0000) nxt_code = CODE_FRAME_SLIP;
  end

  // downstream overhead and line signal
  always_comb begin
    nxt_ovh = '0;
    nxt_ovh.link_up_flag = state_ff inside {ST_PEND_TRANSP, ST_TRANSP};
    nxt_ovh.shutdown_warn_bit =
      !(state_ff inside {ST_PEND_DEACT, ST_TEAR_DOWN});
    unique case (cmd_ff)
      CMD_LINE_ONLY: nxt_ovh.u_only_flag = 1'b0;
      CMD_WAKEUP, CMD_LOOP2, CMD_EXT_REQ: nxt_ovh.u_only_flag = 1'b1;
      default: nxt_ovh.u_only_flag =
        sai_ok_ff && ln.subscriber_side_active_bit;
    endcase
    nxt_ovh.tx_sig = SIG_NONE;
    if (state_ff == ST_ALERT && ms_cnt_ff < 16'(TONE_TX_MS))
      nxt_ovh.tx_sig = SIG_LOCAL_TONE;
    else if (state_ff == ST_EC_TRAIN) nxt_ovh.tx_sig = SIG_EC_TRAIN;
    else if (state_ff == ST_EC_CONV) nxt_ovh.tx_sig = SIG_SYNC_TX;
    else if (state_ff inside {ST_LINE_ON, ST_PEND_TRANSP, ST_TRANSP})
      nxt_ovh.tx_sig = SIG_DATA;
  end

  // subscriber bit counts only once seen valid after deactivation
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sai_ok_ff <= 1'b0;
    end else if (ln.sai_valid && state_ff != ST_DEACT) begin
      sai_ok_ff <= 1'b1;
    end else if (state_ff == ST_DEACT) begin
      sai_ok_ff <= 1'b0;
    end
  end

  // registered outputs; analog loop keeps the tone off the line
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_ff <= CODE_IDLE;
      ovh_ff  <= '0;
      pos_ff  <= 1'b0;
      neg_ff  <= 1'b0;
      pwr_ff  <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      ovh_ff  <= nxt_ovh;
      pos_ff  <= nxt_ovh.tx_sig != SIG_NONE && !analog_ff;
      neg_ff  <= nxt_ovh.tx_sig != SIG_NONE && !analog_ff;
      pwr_ff  <= state_ff != ST_DEACT
                 || tone_cnt_ff >= 4'(TONE_POWERUP);
    end
  end
  assign status_code_o  = code_ff;
  assign ovh_o          = ovh_ff;
  assign line_out_pos_o = pos_ff;
  assign line_out_neg_o = neg_ff;
  assign powered_up_o   = pwr_ff;

  // wishbone: ack one cycle after the request, then low
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= wb_req;
      rdat_ff <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_CMD:  rdat_ff[3:0] <= cmd_ff;
          REG_STAT: begin
            rdat_ff[3:0]            <= code_ff;
            rdat_ff[STAT_PWR_BIT]   <= pwr_ff;
            rdat_ff[STAT_ST_LSB+:16] <= state_ff;
          end
          REG_OVH:  rdat_ff[$bits(lasf_ovh_t)-1:0] <= ovh_ff;
          default:  rdat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // command register written at the acknowledging edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_ff <= CMD_IDLE;
    end else if (ack_ff && wb_cyc_i && wb_stb_i && wb_we_i
                 && wb_adr_i == REG_CMD && wb_sel_i[0]) begin
      cmd_ff <= lasf_cmd_t'(wb_dat_i[3:0]);
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !ack_ff;
  endsequence
  sequence s_ack_pulse;
    ack_ff ##1 !ack_ff;
  endsequence

  a_wb_ack_pulse: assert property (s_wb_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  a_ready_gate: assert property (
    status_code_o == CODE_READY |-> $past(ln.link_up_rx)
      && !$past(loop_on) && $past(state_ff) == ST_TRANSP)
    else $error("ready code without link-up or during loop");
  a_shutdown_code: assert property (
    state_ff inside {ST_RESET, ST_TEST} && slip_cnt_ff == 16'h0000
      |=> status_code_o == CODE_SHUTDOWN_ACK)
    else $error("shutdown ack missing in reset or test");
  a_far_loss: assert property (
    state_ff == ST_TRANSP && !ln.link_up_rx && !loop_on
      && slip_cnt_ff == 16'h0000 |=> status_code_o == CODE_FAR_LOSS)
    else $error("far loss code missing");
  a_fail_code: assert property (
    state_ff == ST_ALERT_ERR && slip_cnt_ff == 16'h0000
      |=> status_code_o == CODE_STARTUP_FAIL)
    else $error("startup fail code missing");
  a_slip_code: assert property (
    slip_cnt_ff != 16'h0000 |=> status_code_o == CODE_FRAME_SLIP)
    else $error("frame slip code missing");
  a_uonly_cmd: assert property (
    cmd_ff == CMD_LINE_ONLY |=> !ovh_ff.u_only_flag)
    else $error("u-only flag set on line-only request");
  a_tone_send: assert property (
    state_ff == ST_ALERT && ms_cnt_ff < 16'(TONE_TX_MS)
      |=> ovh_ff.tx_sig == SIG_LOCAL_TONE)
    else $error("local tone not sent in alerting");
  a_alert_hold: assert property (
    state_ff == ST_ALERT_ERR && !(cmd_ff inside {CMD_RX_CLEAR,
      CMD_ST_RESET, CMD_TEST}) |=> state_ff == ST_ALERT_ERR)
    else $error("alert error left without receiver clear");
  a_deact_quiet: assert property (
    state_ff == ST_DEACT ##1 state_ff == ST_DEACT
      |-> !line_out_pos_o && !line_out_neg_o)
    else $error("line driven while deactivated");
  a_tone_block: assert property (
    state_ff == ST_DEACT && tone_seen_ff && !(cmd_ff inside {CMD_IDLE,
      CMD_ST_RESET, CMD_TEST}) |=> state_ff == ST_DEACT)
    else $error("request honoured after remote tone");
  a_ready_delay: assert property (
    $rose(state_ff == ST_TRANSP) |-> $past(state_ff) == ST_PEND_TRANSP
      && $past(ms_cnt_ff) >= 16'(READY_MS))
    else $error("transparent entered before ready delay");
  a_timer_restart: assert property (
    nxt_state != state_ff |=> ms_cnt_ff == 16'h0000)
    else $error("state timer not restarted on entry");

endmodule

/* testbench/lasf_far_end.sv */
`timescale 1ns/1ns
// far-side model: free-running system bus clocks and wake-up tone
module lasf_far_end
  import lasf_pkg::*;
(
  // tone request and receiver levels from the bench
  input  wire logic       tone_on_i,
  input  wire lasf_line_t rx_i,
  // bundle seen by the block
  output lasf_line_t      line_o
);
  logic bclk  = 1'h0;
  logic fsync = 1'h0;
  logic wave  = 1'h0;
  int   n     = 0;
  // bus clock runs free, frames every 32 bits keep the phase steady
  always #160 bclk = ~bclk;
  always @(posedge bclk) begin
    n = (n + 1) % 32;
    fsync = (n == 0);
  end
  // tone stops dead when off so no stray edge reads as a period
  always #640 wave = tone_on_i ? ~wave : 1'h0;
  always_comb begin
    line_o = rx_i;
    line_o.bit_clock_line = bclk;
    line_o.frame_sync_line = fsync;
    line_o.tone_env = tone_on_i;
    line_o.tone_wave = wave;
  end
endmodule

/* testbench/lasf_top_tb.sv */
`timescale 1ns/1ns
// self-checking bench for the activation status block
module lasf_top_tb
  import lasf_pkg::*;
;
  logic        clk_i = 1'h0;
  logic        rst_b_i = 1'h0;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic        tone = 1'h0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic        ack, pos, neg, pwr;
  lasf_line_t  rx = '0;
  lasf_line_t  line;
  lasf_code_t  code;
  lasf_ovh_t   ovh;
  int          err_total = 0;
  int          n_tests = 0;
  // 25 MHz system clock
  always #20 clk_i = ~clk_i;
  lasf_far_end far_u (.tone_on_i(tone), .rx_i(rx), .line_o(line));
  // short timers keep the run small
  lasf_top #(.SUP_MS(20), .EC_MS(5), .SYNC_MS(5), .MS_FRAMES(1),
    .SLIP_CYCLES(50)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .line_i(line), .status_code_o(code), .ovh_o(ovh),
    .line_out_pos_o(pos), .line_out_neg_o(neg), .powered_up_o(pwr));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // sample just past the edge, once registers have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // classic cycle: hold until ack is sampled, release at that edge
  task automatic wb(input logic w, input logic [3:0] a, input int d);
    int k;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 20 && ack !== 1'h1; k++) tick(1);
    if (k == 20) err_total++;
    rd = dat_o;
    @(posedge clk_i);
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic t_reset;
    tick(1);
    chk("code", code, CODE_IDLE);
    chk("line", {pos, neg, pwr}, 3'h0);
    chk("ovh", ovh, 6'h10);
    wb(1'h0, REG_STAT, 0);
    chk("state", rd[31:16], ST_DEACT);
    wb(1'h0, 4'hC, 0);
    chk("unmapped", rd, 0);
    // a write with no byte lane enabled must leave the command alone
    @(posedge clk_i);
    sel <= 4'h0;
    wb(1'h1, REG_CMD, CMD_TEST);
    sel <= 4'hF;
    wb(1'h0, REG_CMD, 0);
    chk("sel_off", rd[3:0], CMD_IDLE);
    $display("test reset done");
  endtask
  task automatic t_tone;
    @(posedge clk_i);
    tone <= 1'h1;
    tick(330);
    chk("pwr_up", pwr, 1);
    @(posedge clk_i);
    tone <= 1'h0;
    tick(40);
    chk("pwr_down", pwr, 0);
    $display("test tone done");
  endtask
  task automatic t_slip;
    @(posedge clk_i);
    rx.buffer_slip <= 1'h1;
    tick(10);
    chk("slip", code, CODE_FRAME_SLIP);
    tick(35);
    chk("slip_held", code, CODE_FRAME_SLIP);
    tick(25);
    chk("slip_end", code, CODE_IDLE);
    @(posedge clk_i);
    rx.buffer_slip <= 1'h0;
    $display("test slip done");
  endtask
  task automatic t_alert;
    wb(1'h1, REG_CMD, CMD_LINE_ONLY);
    tick(6);
    chk("uoa0", ovh.u_only_flag, 0);
    chk("tone_tx", {ovh.tx_sig, pos}, {SIG_LOCAL_TONE, 1'h1});
    wb(1'h1, REG_CMD, CMD_WAKEUP);
    tick(6);
    chk("uoa1", ovh.u_only_flag, 1);
    tick(6000);
    wb(1'h0, REG_STAT, 0);
    chk("alert_err", rd[31:16], ST_ALERT_ERR);
    wb(1'h1, REG_CMD, CMD_ST_RESET);
    tick(6);
    chk("shutdown_ack_code", code, CODE_SHUTDOWN_ACK);
    $display("test alert done");
  endtask
  // remote tone start-up through transparent, then a failure and recovery
  task automatic t_walk;
    wb(1'h1, REG_CMD, CMD_TEARDOWN);
    @(posedge clk_i);
    tone <= 1'h1;
    tick(420);
    wb(1'h1, REG_CMD, CMD_WAKEUP);
    tick(4);
    wb(1'h0, REG_STAT, 0);
    chk("tone_lock", rd[31:16], ST_DEACT);
    wb(1'h1, REG_CMD, CMD_IDLE);
    tick(4);
    chk("awake", code, CODE_WAKEUP);
    @(posedge clk_i);
    tone <= 1'h0;
    tick(8);
    chk("ec_train", {ovh.tx_sig, pos, neg}, {SIG_EC_TRAIN, 2'h3});
    @(posedge clk_i);
    rx.residual_quiet <= 1'h1;
    tick(8);
    chk("ec_conv", ovh.tx_sig, SIG_SYNC_TX);
    @(posedge clk_i);
    rx.residual_level_seen <= 1'h1;
    tick(8);
    chk("line_on", {code, ovh.tx_sig}, {CODE_LINE_SYNC, SIG_DATA});
    @(posedge clk_i);
    rx.link_up_rx <= 1'h1;
    tick(8);
    chk("act_tx", ovh.link_up_flag, 1);
    tick(5800);
    chk("pend", code, CODE_LINE_SYNC);
    tick(400);
    chk("ready", code, CODE_READY);
    @(posedge clk_i);
    rx.link_up_rx <= 1'h0;
    tick(8);
    chk("far_loss", code, CODE_FAR_LOSS);
    @(posedge clk_i);
    rx.link_up_rx <= 1'h1;
    tick(8);
    chk("ready_again", code, CODE_READY);
    @(posedge clk_i);
    rx.long_signal_loss <= 1'h1;
    tick(8);
    chk("sig_loss", code, CODE_SIGNAL_LOSS);
    wb(1'h1, REG_CMD, CMD_RX_CLEAR);
    rx.long_signal_loss <= 1'h0;
    tone <= 1'h1;
    tick(420);
    wb(1'h0, REG_STAT, 0);
    chk("awake_err", rd[31:16], ST_AWAKE_ERR);
    chk("wake_code", rd[3:0], CODE_WAKEUP);
    wb(1'h1, REG_CMD, CMD_IDLE);
    tone <= 1'h0;
    $display("test walk done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well past the expected run length
  initial begin
    #1000000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'h1;
    t_reset();
    t_tone();
    t_slip();
    t_alert();
    t_walk();
    close_out();
  end
endmodule
